// *** rtl/rmc_config_regs.sv ***
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
module rmc_config_regs (
    input  wire logic        aclk,             // system clock
    input  wire logic        aresetn,          // sync reset, low
    input  wire logic [7:0]  awaddr,           // write address
    input  wire logic        awvalid,          // write address valid
    output logic             awready,          // write address ready
    input  wire logic [31:0] wdata,            // write data
    input  wire logic [3:0]  wstrb,            // write strobes
    input  wire logic        wvalid,           // write data valid
    output logic             wready,           // write data ready
    output logic [1:0]       bresp,            // write response
    output logic             bvalid,           // write response valid
    input  wire logic        bready,           // write response ready
    input  wire logic [7:0]  araddr,           // read address
    input  wire logic        arvalid,          // read address valid
    output logic             arready,          // read address ready
    output logic [31:0]      rdata,            // read data
    output logic [1:0]       rresp,            // read response
    output logic             rvalid,           // read data valid
    input  wire logic        rready,           // read data ready
    input  wire logic        xtal_tick,        // one pulse per xtal cycle
    input  wire logic [6:0]  fifo_fill,        // fifo fill in bytes
    input  wire logic        standby,          // 1 standby, 0 tx/rx
    input  wire logic        ook_rx,           // OOK receive active
    output var rmc_pkg::rmc_mode_t data_mode,  // data operation mode
    output logic [13:0]      deviation_count,  // xtal cycles per fdev
    output logic [13:0]      rate_count,       // xtal cycles per bit
    output logic             dev_tick,         // deviation rate pulse
    output logic             rate_tick,        // bit rate pulse
    output logic [7:0]       floor_level_out,  // applied OOK floor
    output logic [6:0]       fifo_depth_bytes, // fifo size in bytes
    output logic             fifo_thr_flag,    // fill past threshold, or at it in standby
    output logic [7:0]       synth_ref,        // active R count
    output logic [7:0]       synth_prescale,   // active P count
    output logic [7:0]       synth_scale,      // active S count
    output logic             irq               // level interrupt
);
    import rmc_pkg::*;

    logic [7:0] deviation_divider;
    logic [6:0] rate_divider;
    logic [7:0] floor_level;
    logic [7:0] fifo_cfg_reg;
    logic [7:0] ref_a_reg, pre_a_reg, scl_a_reg;
    logic [7:0] ref_b_reg, pre_b_reg, scl_b_reg;
    logic [2:0] ctrl_reg;
    logic [1:0] irq_mask_reg, irq_stat_reg, irq_set;
    logic       aw_full, w_full;
    logic [5:0] aw_idx;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        do_write, wr_en, wr_hit, rd_hit;
    logic [31:0] rd_data;
    logic        thr_rise, sel_prev;
    logic [1:0]  fifo_depth_sel;
    logic [5:0]  fifo_irq_level;
    logic        counter_set_select;

    assign fifo_depth_sel     =
        fifo_cfg_reg[RMC_FIFO_SEL_MSB:RMC_FIFO_SEL_LSB];
    assign fifo_irq_level     = fifo_cfg_reg[RMC_FIFO_LVL_MSB:0];
    assign counter_set_select = ctrl_reg[RMC_CTRL_SET_SEL];

    function automatic logic idx_mapped(input logic [5:0] idx);
        idx_mapped = (idx >= RMC_IDX_FDEV && idx <= RMC_IDX_SCL_B) ||
                     (idx >= RMC_IDX_CTRL && idx <= RMC_IDX_IRQ_MASK);
    endfunction

    // write address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready  <= 1'b0;
            aw_full  <= 1'b0;
            aw_idx   <= '0;
        end else if (awvalid && awready) begin
            awready  <= 1'b0;
            aw_full  <= 1'b1;
            aw_idx   <= awaddr[7:2];
        end else if (do_write) begin
            aw_full  <= 1'b0;
        end else if (!aw_full && !bvalid) begin
            awready  <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready   <= 1'b0;
            w_full   <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (wvalid && wready) begin
            wready   <= 1'b0;
            w_full   <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (do_write) begin
            w_full   <= 1'b0;
        end else if (!w_full && !bvalid) begin
            wready   <= 1'b1;
        end
    end

    assign do_write = aw_full & w_full & ~bvalid;
    assign wr_hit   = idx_mapped(aw_idx);
    assign wr_en    = do_write & wr_hit & w_strb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RMC_RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? RMC_RESP_OKAY : RMC_RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // configuration storage; reserved rate bit is dropped on write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deviation_divider <= RMC_RST_FDEV;
            rate_divider      <= RMC_RST_BRATE;
            floor_level       <= RMC_RST_FLOOR;
            fifo_cfg_reg      <= RMC_RST_FIFO;
            ref_a_reg         <= RMC_RST_REF_A;
            pre_a_reg         <= RMC_RST_PRE_A;
            scl_a_reg         <= RMC_RST_SCL_A;
            ref_b_reg         <= RMC_RST_REF_B;
            pre_b_reg         <= RMC_RST_PRE_B;
            scl_b_reg         <= RMC_RST_SCL_B;
            ctrl_reg          <= RMC_RST_CTRL;
            irq_mask_reg      <= RMC_RST_IRQ;
        end else if (wr_en) begin
            case (aw_idx)
                RMC_IDX_FDEV:     deviation_divider <= w_data_q[7:0];
                RMC_IDX_BRATE:    rate_divider      <= w_data_q[6:0];
                RMC_IDX_FLOOR:    floor_level       <= w_data_q[7:0];
                RMC_IDX_FIFO:     fifo_cfg_reg      <= w_data_q[7:0];
                RMC_IDX_REF_A:    ref_a_reg         <= w_data_q[7:0];
                RMC_IDX_PRE_A:    pre_a_reg         <= w_data_q[7:0];
                RMC_IDX_SCL_A:    scl_a_reg         <= w_data_q[7:0];
                RMC_IDX_REF_B:    ref_b_reg         <= w_data_q[7:0];
                RMC_IDX_PRE_B:    pre_b_reg         <= w_data_q[7:0];
                RMC_IDX_SCL_B:    scl_b_reg         <= w_data_q[7:0];
                RMC_IDX_CTRL:     ctrl_reg          <= w_data_q[2:0];
                RMC_IDX_IRQ_MASK: irq_mask_reg      <= w_data_q[1:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_hit  = idx_mapped(araddr[7:2]);
        rd_data = '0;
        case (araddr[7:2])
            RMC_IDX_FDEV:     rd_data[7:0] = deviation_divider;
            RMC_IDX_BRATE:    rd_data[6:0] = rate_divider;
            RMC_IDX_FLOOR:    rd_data[7:0] = floor_level;
            RMC_IDX_FIFO:     rd_data[7:0] = fifo_cfg_reg;
            RMC_IDX_REF_A:    rd_data[7:0] = ref_a_reg;
            RMC_IDX_PRE_A:    rd_data[7:0] = pre_a_reg;
            RMC_IDX_SCL_A:    rd_data[7:0] = scl_a_reg;
            RMC_IDX_REF_B:    rd_data[7:0] = ref_b_reg;
            RMC_IDX_PRE_B:    rd_data[7:0] = pre_b_reg;
            RMC_IDX_SCL_B:    rd_data[7:0] = scl_b_reg;
            RMC_IDX_CTRL:     rd_data[2:0] = ctrl_reg;
            RMC_IDX_IRQ_STAT: rd_data[1:0] = irq_stat_reg;
            RMC_IDX_IRQ_MASK: rd_data[1:0] = irq_mask_reg;
            default:          rd_data      = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RMC_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data;
            rresp   <= rd_hit ? RMC_RESP_OKAY : RMC_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    assign irq_set[RMC_IRQ_FIFO_THR] = thr_rise;
    assign irq_set[RMC_IRQ_SET_SWAP] = counter_set_select ^ sel_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= RMC_RST_IRQ;
            sel_prev     <= RMC_RST_CTRL[RMC_CTRL_SET_SEL];
            irq          <= 1'b0;
        end else begin
            if (wr_en && aw_idx == RMC_IDX_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~w_data_q[1:0]) | irq_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
            sel_prev <= counter_set_select;
            irq      <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // derived controls for modem, fifo and synthesizer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_mode        <= RMC_MODE_CONT;
            deviation_count  <= '0;
            rate_count       <= '0;
            floor_level_out  <= '0;
            fifo_depth_bytes <= '0;
            synth_ref        <= RMC_RST_REF_A;
            synth_prescale   <= RMC_RST_PRE_A;
            synth_scale      <= RMC_RST_SCL_A;
        end else begin
            case ({ctrl_reg[RMC_CTRL_MODE_HI], ctrl_reg[RMC_CTRL_MODE_LO]})
                2'b00:   data_mode <= RMC_MODE_CONT;
                2'b01:   data_mode <= RMC_MODE_BUFFER;
                default: data_mode <= RMC_MODE_PACKET;
            endcase
            deviation_count <= ({6'h00, deviation_divider} + 14'h1)
                               << RMC_DEV_SHIFT;
            rate_count      <= ({7'h00, rate_divider} + 14'h1)
                               << RMC_RATE_SHIFT;
            floor_level_out <= ook_rx ? floor_level : 8'h00;
            fifo_depth_bytes <= ({5'h00, fifo_depth_sel} + 7'h1)
                                << RMC_DEPTH_SHIFT;
            if (!counter_set_select) begin
                synth_ref      <= ref_a_reg;
                synth_prescale <= pre_a_reg;
                synth_scale    <= scl_a_reg;
            end else begin
                synth_ref      <= ref_b_reg;
                synth_prescale <= pre_b_reg;
                synth_scale    <= scl_b_reg;
            end
        end
    end

    rmc_div_if dev_if ();
    rmc_div_if rate_if ();
    assign dev_if.divisor   = deviation_count;
    assign dev_if.ref_tick  = xtal_tick;
    assign rate_if.divisor  = rate_count;
    assign rate_if.ref_tick = xtal_tick;
    assign dev_tick         = dev_if.tick;
    assign rate_tick        = rate_if.tick;

    rmc_tick_div u_dev_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dv      (dev_if.div)
    );
    rmc_tick_div u_rate_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dv      (rate_if.div)
    );

    rmc_fifo_thr u_fifo_thr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .fill    (fifo_fill),
        .level   (fifo_irq_level),
        .standby (standby),
        .above   (fifo_thr_flag),
        .rise    (thr_rise)
    );

    property p_mode_packet;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_reg[RMC_CTRL_MODE_HI] |=> data_mode == RMC_MODE_PACKET;
    endproperty
    a_mode_packet: assert property (p_mode_packet)
        else $error("high data mode bit did not give packet mode");

    property p_mode_buffer;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_reg[1:0] == 2'b01 |=> data_mode == RMC_MODE_BUFFER;
    endproperty
    a_mode_buffer: assert property (p_mode_buffer)
        else $error("low data mode bit alone did not give buffer mode");

    property p_dev_count;
        @(posedge aclk) disable iff (!aresetn)
        aresetn |=> deviation_count ==
            ({6'h00, $past(deviation_divider)} + 14'h1) * 14'd32;
    endproperty
    a_dev_count: assert property (p_dev_count)
        else $error("deviation count not 32 times field plus one");

    property p_rate_count;
        @(posedge aclk) disable iff (!aresetn)
        aresetn |=> rate_count ==
            ({7'h00, $past(rate_divider)} + 14'h1) * 14'd64;
    endproperty
    a_rate_count: assert property (p_rate_count)
        else $error("rate count not 64 times field plus one");

    property p_rsvd_zero;
        @(posedge aclk) disable iff (!aresetn)
        rvalid && $past(araddr[7:2]) == RMC_IDX_BRATE && $rose(rvalid)
        |-> rdata[31:7] == '0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved rate bit read as one");

    property p_floor;
        @(posedge aclk) disable iff (!aresetn)
        ook_rx ##1 $stable(floor_level) |-> floor_level_out == floor_level;
    endproperty
    a_floor: assert property (p_floor)
        else $error("floor not applied in OOK receive");

    property p_depth;
        @(posedge aclk) disable iff (!aresetn)
        fifo_depth_sel == 2'b10 ##1 fifo_depth_sel == 2'b10
        |-> fifo_depth_bytes == 7'd48;
    endproperty
    a_depth: assert property (p_depth)
        else $error("depth code two did not give 48 bytes");

    property p_thr_irq;
        @(posedge aclk) disable iff (!aresetn)
        thr_rise |=> irq_stat_reg[RMC_IRQ_FIFO_THR];
    endproperty
    a_thr_irq: assert property (p_thr_irq)
        else $error("threshold crossing lost");

    property p_set_a;
        @(posedge aclk) disable iff (!aresetn)
        !counter_set_select |=> synth_ref == $past(ref_a_reg) &&
            synth_prescale == $past(pre_a_reg);
    endproperty
    a_set_a: assert property (p_set_a)
        else $error("first counter set not used");

    property p_set_b;
        @(posedge aclk) disable iff (!aresetn)
        counter_set_select |=> synth_scale == $past(scl_b_reg) &&
            synth_ref == $past(ref_b_reg);
    endproperty
    a_set_b: assert property (p_set_b)
        else $error("second counter set not used");

    property p_readback;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && aw_idx == RMC_IDX_FDEV |=>
            deviation_divider == $past(w_data_q[7:0]);
    endproperty
    a_readback: assert property (p_readback)
        else $error("written deviation field not held");

    c_write: cover property (@(posedge aclk) bvalid && bready);
    c_read: cover property (@(posedge aclk) rvalid && rready);
    c_irq: cover property (@(posedge aclk) irq);
    c_packet: cover property (@(posedge aclk)
        data_mode == RMC_MODE_PACKET);
endmodule
`default_nettype wire

// *** rtl/rmc_div_if.sv ***
`default_nettype none
interface rmc_div_if;
    logic [13:0] divisor;
    logic        ref_tick;
    logic        tick;
    modport div (input divisor, input ref_tick, output tick);
    modport ctl (output divisor, output ref_tick, input tick);
endinterface
`default_nettype wire

// *** rtl/rmc_fifo_thr.sv ***
`default_nettype none
module rmc_fifo_thr (
    input  wire logic       aclk,    // system clock
    input  wire logic       aresetn, // sync reset, low
    input  wire logic [6:0] fill,    // fifo fill in bytes
    input  wire logic [5:0] level,   // threshold field
    input  wire logic       standby, // 1 standby, 0 tx/rx
    output logic            above,   // threshold condition
    output logic            rise     // condition just became true
);
    logic above_next;

    // standby fires at the level, tx/rx only once past it
    always_comb begin
        if (standby) begin
            above_next = fill >= {1'b0, level};
        end else begin
            above_next = fill > {1'b0, level};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            above <= 1'b0;
            rise  <= 1'b0;
        end else begin
            above <= above_next;
            rise  <= above_next & ~above;
        end
    end
endmodule
`default_nettype wire

// *** rtl/rmc_pkg.sv ***
`default_nettype none
package rmc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] RMC_IDX_FDEV      = 6'h02;
    localparam logic [5:0] RMC_IDX_BRATE     = 6'h03;
    localparam logic [5:0] RMC_IDX_FLOOR     = 6'h04;
    localparam logic [5:0] RMC_IDX_FIFO      = 6'h05;
    localparam logic [5:0] RMC_IDX_REF_A     = 6'h06;
    localparam logic [5:0] RMC_IDX_PRE_A     = 6'h07;
    localparam logic [5:0] RMC_IDX_SCL_A     = 6'h08;
    localparam logic [5:0] RMC_IDX_REF_B     = 6'h09;
    localparam logic [5:0] RMC_IDX_PRE_B     = 6'h0a;
    localparam logic [5:0] RMC_IDX_SCL_B     = 6'h0b;
    localparam logic [5:0] RMC_IDX_CTRL      = 6'h10;
    localparam logic [5:0] RMC_IDX_IRQ_STAT  = 6'h11;
    localparam logic [5:0] RMC_IDX_IRQ_MASK  = 6'h12;
    // reset values
    localparam logic [7:0] RMC_RST_FDEV      = 8'h03;
    localparam logic [6:0] RMC_RST_BRATE     = 7'h07;
    localparam logic [7:0] RMC_RST_FLOOR     = 8'h0c;
    localparam logic [7:0] RMC_RST_FIFO      = 8'h0f;
    localparam logic [7:0] RMC_RST_REF_A     = 8'h77;
    localparam logic [7:0] RMC_RST_PRE_A     = 8'h64;
    localparam logic [7:0] RMC_RST_SCL_A     = 8'h32;
    localparam logic [7:0] RMC_RST_REF_B     = 8'h74;
    localparam logic [7:0] RMC_RST_PRE_B     = 8'h62;
    localparam logic [7:0] RMC_RST_SCL_B     = 8'h32;
    localparam logic [2:0] RMC_RST_CTRL      = 3'h0;
    localparam logic [1:0] RMC_RST_IRQ       = 2'h0;
    // field positions
    localparam int RMC_CTRL_MODE_LO  = 0;
    localparam int RMC_CTRL_MODE_HI  = 1;
    localparam int RMC_CTRL_SET_SEL  = 2;
    localparam int RMC_FIFO_SEL_MSB  = 7;
    localparam int RMC_FIFO_SEL_LSB  = 6;
    localparam int RMC_FIFO_LVL_MSB  = 5;
    localparam int RMC_IRQ_FIFO_THR  = 0;
    localparam int RMC_IRQ_SET_SWAP  = 1;
    // divider scaling
    localparam int RMC_DEV_SHIFT     = 5;
    localparam int RMC_RATE_SHIFT    = 6;
    localparam int RMC_DEPTH_SHIFT   = 4;
    localparam int RMC_XTAL_REF_HZ   = 12_800_000;
    localparam int RMC_DIV_W         = 14;
    // bus responses
    localparam logic [1:0] RMC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] RMC_RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        RMC_MODE_CONT   = 3'b001,
        RMC_MODE_BUFFER = 3'b010,
        RMC_MODE_PACKET = 3'b100
    } rmc_mode_t;
endpackage
`default_nettype wire

// *** rtl/rmc_tick_div.sv ***
`default_nettype none
module rmc_tick_div (
    input  wire logic aclk,    // system clock
    input  wire logic aresetn, // sync reset, low
    rmc_div_if.div    dv       // divisor in, tick out
);
    import rmc_pkg::*;
    logic [RMC_DIV_W-1:0] cnt_reg;
    logic                 tick_reg;

    assign dv.tick = tick_reg;

    // one tick every divisor reference ticks, so the rate scales with xtal
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (dv.ref_tick) begin
            if (cnt_reg >= dv.divisor - 14'h1) begin
                cnt_reg  <= '0;
                tick_reg <= 1'b1;
            end else begin
                cnt_reg  <= cnt_reg + 14'h1;
                tick_reg <= 1'b0;
            end
        end else begin
            tick_reg <= 1'b0;
        end
    end

    // after the divisor drops to or below the count, the count wraps at the next reference tick
    property p_cnt_bound;
        @(posedge aclk) disable iff (!aresetn)
        dv.divisor != 14'h0 && $stable(dv.divisor) && $past(dv.ref_tick)
        |-> cnt_reg < dv.divisor;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound)
        else $error("divider count past its divisor");
endmodule
`default_nettype wire

// *** testbench/rmc_config_regs_tb.sv ***
`default_nettype none
module rmc_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rmc_pkg::*;
    logic        aclk      = 0;
    logic        aresetn   = 0;
    logic [7:0]  awaddr    = '0;
    logic        awvalid   = 0;
    logic [31:0] wdata     = '0;
    logic [3:0]  wstrb     = '0;
    logic        wvalid    = 0;
    logic        bready    = 0;
    logic [7:0]  araddr    = '0;
    logic        arvalid   = 0;
    logic        rready    = 0;
    logic        xtal_tick;
    logic        xtal_half = 0;
    logic [6:0]  fifo_fill = '0;
    logic        standby   = 0;
    logic        ook_rx    = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        dev_tick, rate_tick, fifo_thr_flag;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [13:0] deviation_count, rate_count;
    logic [7:0]  floor_level_out, synth_ref, synth_prescale, synth_scale;
    wire [23:0]  synth_all = {synth_ref, synth_prescale, synth_scale};
    logic [6:0]  fifo_depth_bytes;
    rmc_mode_t   data_mode;
    int          num_errors = 0;
    int          tests_run  = 0;
    logic [5:0]  idx_t [13] = '{RMC_IDX_FDEV, RMC_IDX_BRATE, RMC_IDX_FLOOR,
        RMC_IDX_FIFO, RMC_IDX_REF_A, RMC_IDX_PRE_A, RMC_IDX_SCL_A,
        RMC_IDX_REF_B, RMC_IDX_PRE_B, RMC_IDX_SCL_B, RMC_IDX_CTRL,
        RMC_IDX_IRQ_STAT, RMC_IDX_IRQ_MASK};
    logic [7:0]  rst_t [13] = '{RMC_RST_FDEV, {1'b0, RMC_RST_BRATE},
        RMC_RST_FLOOR, RMC_RST_FIFO, RMC_RST_REF_A, RMC_RST_PRE_A,
        RMC_RST_SCL_A, RMC_RST_REF_B, RMC_RST_PRE_B, RMC_RST_SCL_B,
        8'h00, 8'h00, 8'h00};

    rmc_config_regs i_rmc_config_regs (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .xtal_tick(xtal_tick),
        .fifo_fill(fifo_fill), .standby(standby), .ook_rx(ook_rx),
        .data_mode(data_mode), .deviation_count(deviation_count),
        .rate_count(rate_count), .dev_tick(dev_tick),
        .rate_tick(rate_tick), .floor_level_out(floor_level_out),
        .fifo_depth_bytes(fifo_depth_bytes),
        .fifo_thr_flag(fifo_thr_flag), .synth_ref(synth_ref),
        .synth_prescale(synth_prescale), .synth_scale(synth_scale),
        .irq(irq));

    initial begin
        forever #5 aclk = ~aclk;
    end

    // crystal pulse every clock, or every other clock at half rate
    always @(posedge aclk) begin
        xtal_tick <= xtal_half ? ~xtal_tick : 1'b1;
    end

    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(logic [5:0] idx, logic [7:0] d, logic [1:0] er);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        wstrb   <= 4'hf;
        awvalid <= 1;
        wvalid  <= 1;
        bready  <= 1;
        for (int k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 0;
            if (wvalid && wready)
                wvalid <= 0;
            if (bvalid === 1'b1)
                break;
        end
        chk("bvalid", 1, 32'(bvalid));
        chk("bresp", 32'(er), 32'(bresp));
        bready <= 0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic rd(logic [5:0] idx, logic [7:0] ed, logic [1:0] er);
        araddr  <= {idx, 2'b00};
        arvalid <= 1;
        rready  <= 1;
        for (int k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 0;
            if (rvalid === 1'b1)
                break;
        end
        chk("rvalid", 1, 32'(rvalid));
        chk("rdata", {24'h0, ed}, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        rready <= 0;
        @(posedge aclk);
    endtask

    task automatic tick_gap(bit sel, int exp);
        int n;
        n = 0;
        repeat (2) begin
            @(posedge aclk);
            while (!(sel ? rate_tick : dev_tick) && n < 5000) begin
                n++;
                @(posedge aclk);
            end
            n = 0;
        end
        @(posedge aclk);
        while (!(sel ? rate_tick : dev_tick) && n < 5000) begin
            n++;
            @(posedge aclk);
        end
        chk("tick gap", exp, n + 1);
    endtask

    task automatic t_reset;
        foreach (idx_t[i])
            rd(idx_t[i], rst_t[i], RMC_RESP_OKAY);
        chk("mode", 32'(RMC_MODE_CONT), 32'(data_mode));
        chk("dev", 128, 32'(deviation_count));
        chk("rate", 512, 32'(rate_count));
        chk("depth", 16, 32'(fifo_depth_bytes));
        chk("synth", 24'h776432, 32'(synth_all));
    endtask

    task automatic t_limits;
        wr(RMC_IDX_BRATE, 8'h7f, RMC_RESP_OKAY);
        rd(RMC_IDX_BRATE, 8'h7f, RMC_RESP_OKAY);
        chk("rate", 64 * 128, 32'(rate_count));
        wr(RMC_IDX_FDEV, 8'hff, RMC_RESP_OKAY);
        chk("dev", 32 * 256, 32'(deviation_count));
        wr(RMC_IDX_FDEV, 8'h00, RMC_RESP_OKAY);
        wr(RMC_IDX_BRATE, 8'h00, RMC_RESP_OKAY);
        tick_gap(0, 32);
        tick_gap(1, 64);
        xtal_half <= 1;
        tick_gap(0, 64);
        xtal_half <= 0;
        wr(6'h3f, 8'h55, RMC_RESP_SLVERR);
        rd(6'h3f, 8'h00, RMC_RESP_SLVERR);
    endtask

    task automatic t_modes;
        rmc_mode_t e;
        for (int m = 0; m < 4; m++) begin
            e = m[1] ? RMC_MODE_PACKET : (m[0] ? RMC_MODE_BUFFER
                                                : RMC_MODE_CONT);
            wr(RMC_IDX_CTRL, 8'(m), RMC_RESP_OKAY);
            chk("mode", 32'(e), 32'(data_mode));
        end
        for (int s = 3; s >= 0; s--) begin
            wr(RMC_IDX_FIFO, {2'(s), 6'h0f}, RMC_RESP_OKAY);
            chk("depth", 16 * (s + 1), 32'(fifo_depth_bytes));
        end
    endtask

    task automatic t_floor_thr;
        chk("floor off", 0, 32'(floor_level_out));
        ook_rx <= 1;
        repeat (3) @(posedge aclk);
        chk("floor", 32'h0c, 32'(floor_level_out));
        standby   <= 1;
        fifo_fill <= 7'd15;
        repeat (3) @(posedge aclk);
        chk("thr stby", 1, 32'(fifo_thr_flag));
        standby <= 0;
        repeat (3) @(posedge aclk);
        chk("thr txrx eq", 0, 32'(fifo_thr_flag));
        fifo_fill <= 7'd16;
        repeat (3) @(posedge aclk);
        chk("thr txrx gt", 1, 32'(fifo_thr_flag));
        rd(RMC_IDX_IRQ_STAT, 8'h01, RMC_RESP_OKAY);
        wr(RMC_IDX_IRQ_STAT, 8'h01, RMC_RESP_OKAY);
    endtask

    task automatic t_sets_irq;
        wr(RMC_IDX_CTRL, 8'h04, RMC_RESP_OKAY);
        chk("synth b", 24'h746232, 32'(synth_all));
        rd(RMC_IDX_IRQ_STAT, 8'h02, RMC_RESP_OKAY);
        chk("irq masked", 0, 32'(irq));
        wr(RMC_IDX_IRQ_MASK, 8'h02, RMC_RESP_OKAY);
        chk("irq", 1, 32'(irq));
        wr(RMC_IDX_IRQ_STAT, 8'h02, RMC_RESP_OKAY);
        chk("irq clr", 0, 32'(irq));
        wr(RMC_IDX_CTRL, 8'h00, RMC_RESP_OKAY);
        chk("synth a", 24'h776432, 32'(synth_all));
    endtask

    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_limits();
        t_modes();
        t_floor_thr();
        t_sets_irq();
        give_verdict();
    end
endmodule
`default_nettype wire
